//--- inc/scp_defines.vh
// Constants for the serial configuration port: instruction layout,
// internal register offsets, field positions and reset values.
// Assumes inclusion by bare name from the rtl files.
//
// Notes on behaviour
// - Frames are taken only while frame_select_n is low; otherwise clock and data ignored.
// - A frame starts at the select fall; the first rising clock edge begins it.
// - Select held low forever keeps the port enabled and streaming frame after frame.
// - Select may rise between bytes of a fixed-length transfer as a stall; in a streaming transfer it ends the frame.
// - Select high puts the data pin in high impedance; secondary functions are enabled only once the port is idle.
// - Every frame opens with a sixteen-bit instruction before any data bytes.
// - Two length bits in the instruction set how many data bytes follow.
// - All data moves as eight-bit bytes.
// - The read/write bit of the instruction decides whether the data pin turns around.
// - Incoming bits are sampled on each rising serial clock edge.
// - Readback bits are driven on falling edges for sampling at the next rise.
// - After the last instruction bit of a read the pin turns to output within half a period.
// - Bit order defaults to MSB first; a config bit selects LSB first, both supported.
// - Clock and select are inputs; data pin is input when writing, output only on readback.
// - Soft reset bit restores user registers to defaults and clears itself.
// - Channel bits pick targets; writes go to all selected, full-select read returns channel 0.

`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// ****************************************
// Instruction word
// ****************************************
`define SCP_ADDR_W      13
`define SCP_INSTR_LAST  4'hf
`define SCP_BYTE_LAST   4'h7
`define SCP_RW_BIT      15
`define SCP_LEN_HI_BIT  14
`define SCP_LEN_LO_BIT  13
`define SCP_LEN_STREAM  2'h3

// ****************************************
// Internal registers
// ****************************************
`define SCP_ADDR_CFG    13'h0000
`define SCP_ADDR_CHAN   13'h0005
`define SCP_CFG_FIXED   8'h18
`define SCP_CFG_LSB_HI  6
`define SCP_CFG_LSB_LO  1
`define SCP_CFG_SRST_HI 5
`define SCP_CFG_SRST_LO 2
`define SCP_CHAN_N      4
`define SCP_CHAN_DEF    4'hf

`endif

//--- rtl/scp_sync.v
// Two-stage synchroniser for one asynchronous input pin.
// Assumes the output is read only in the clk_i domain.
`timescale 1ns/1ps
module scp_sync #(
    parameter RST_VAL = 1'b0          // Level held during reset
) (
    input  wire clk_i,                // System clock
    input  wire rst_i,                // Synchronous reset, active high
    input  wire d_i,                  // Asynchronous input
    output wire q_o                   // Synchronised level
);

    reg meta_reg;
    reg sync_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule // scp_sync

//--- rtl/scp_port.v
// Three-wire serial configuration port: instruction and data phases,
// streaming, stalls, bit order, readback turnaround, two internal registers.
// Assumes the serial pins are asynchronous to clk_i and run well below it;
// the user register file answers reg_rd_o in the same cycle on reg_rdata_i.
`timescale 1ns/1ps
`include "scp_defines.vh"
module scp_port (
    input  wire                    clk_i,             // System clock, 100 MHz
    input  wire                    rst_i,             // Synchronous reset, active high
    input  wire                    sclk_i,            // Serial clock pin
    input  wire                    frame_select_n_i,  // Frame select pin, active low
    input  wire                    sdio_i,            // Data pin input level
    output reg                     sdio_o,            // Data pin output value
    output reg                     sdio_oe_o,         // Data pin output enable
    output reg                     alt_func_en_o,     // Secondary pin functions enabled
    output reg  [`SCP_ADDR_W-1:0]  reg_addr_o,        // User register address
    output reg  [7:0]              reg_wdata_o,       // User register write data
    output reg                     reg_wr_o,          // User register write strobe
    output reg  [`SCP_CHAN_N-1:0]  reg_wr_chan_o,     // Channels targeted by write
    output reg                     reg_rd_o,          // User register read strobe
    output reg  [1:0]              reg_rd_chan_o,     // Channel returned by read
    input  wire [7:0]              reg_rdata_i,       // User register read data
    output reg                     soft_reset_o,      // Pulse: restore user defaults
    output wire                    lsb_first_o,       // Current bit order
    output wire [`SCP_CHAN_N-1:0]  chan_sel_o         // Current channel selection
);

    // ****************************************
    // States
    // ****************************************
    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_INSTR = 2'b01;
    localparam [1:0] ST_DATA  = 2'b10;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire sclk_s;
    wire csb_s;
    wire sdio_s;

    scp_sync #(.RST_VAL(1'b0)) u_sync_sclk (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (sclk_i),
        .q_o   (sclk_s)
    );

    scp_sync #(.RST_VAL(1'b1)) u_sync_csb (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (frame_select_n_i),
        .q_o   (csb_s)
    );

    scp_sync #(.RST_VAL(1'b0)) u_sync_sdio (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (sdio_i),
        .q_o   (sdio_s)
    );

    // ****************************************
    // Registers
    // ****************************************
    reg                    sclk_d_reg;
    reg                    csb_d_reg;
    reg [1:0]              state_reg;
    reg [3:0]              cnt_reg;
    reg [15:0]             instr_reg;
    reg [7:0]              rx_reg;
    reg [7:0]              tx_reg;
    reg [`SCP_ADDR_W-1:0]  addr_reg;
    reg                    read_reg;
    reg                    stream_reg;
    reg [1:0]              left_reg;
    reg                    lsb_reg;
    reg [`SCP_CHAN_N-1:0]  chan_reg;

    reg [1:0]              state_next;
    reg [3:0]              cnt_next;
    reg [15:0]             instr_next;
    reg [7:0]              rx_next;
    reg [7:0]              tx_next;
    reg [`SCP_ADDR_W-1:0]  addr_next;
    reg                    read_next;
    reg                    stream_next;
    reg [1:0]              left_next;
    reg                    lsb_next;
    reg [`SCP_CHAN_N-1:0]  chan_next;
    reg                    dout_next;
    reg                    oe_next;
    reg                    alt_next;
    reg [`SCP_ADDR_W-1:0]  raddr_next;
    reg [7:0]              wdata_next;
    reg                    wr_next;
    reg [`SCP_CHAN_N-1:0]  wchan_next;
    reg                    rd_next;
    reg [1:0]              rchan_next;
    reg                    srst_next;
    reg [7:0]              rd_mux;
    reg [1:0]              first_chan;

    // ****************************************
    // Edge detection and shift values
    // ****************************************
    wire sclk_rise = sclk_s & ~sclk_d_reg & ~csb_s;
    wire sclk_fall = ~sclk_s & sclk_d_reg & ~csb_s;
    wire csb_rise  = csb_s & ~csb_d_reg;
    wire mid_byte  = (cnt_reg[2:0] != 3'h0);

    wire [15:0] instr_shift = lsb_reg ? {sdio_s, instr_reg[15:1]}
                                      : {instr_reg[14:0], sdio_s};
    wire [7:0]  rx_shift    = lsb_reg ? {sdio_s, rx_reg[7:1]}
                                      : {rx_reg[6:0], sdio_s};
    wire [`SCP_ADDR_W-1:0] addr_step = lsb_reg ? addr_reg + 13'h0001
                                               : addr_reg - 13'h0001;
    wire [1:0]  len_code    = {instr_shift[`SCP_LEN_HI_BIT], instr_shift[`SCP_LEN_LO_BIT]};

    assign lsb_first_o = lsb_reg;
    assign chan_sel_o  = chan_reg;

    // Lowest selected channel answers a read
    always @* begin
        if (chan_reg[0]) begin
            first_chan = 2'h0;
        end else if (chan_reg[1]) begin
            first_chan = 2'h1;
        end else if (chan_reg[2]) begin
            first_chan = 2'h2;
        end else if (chan_reg[3]) begin
            first_chan = 2'h3;
        end else begin
            first_chan = 2'h0;
        end
    end

    // Readback source for the addressed byte
    always @* begin
        if (reg_addr_o == `SCP_ADDR_CFG) begin
            rd_mux = `SCP_CFG_FIXED | {1'b0, lsb_reg, 4'h0, lsb_reg, 1'b0};
        end else if (reg_addr_o == `SCP_ADDR_CHAN) begin
            rd_mux = {4'h0, chan_reg};
        end else begin
            rd_mux = reg_rdata_i;
        end
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always @* begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        instr_next  = instr_reg;
        rx_next     = rx_reg;
        tx_next     = tx_reg;
        addr_next   = addr_reg;
        read_next   = read_reg;
        stream_next = stream_reg;
        left_next   = left_reg;
        lsb_next    = lsb_reg;
        chan_next   = chan_reg;
        dout_next   = sdio_o;
        raddr_next  = reg_addr_o;
        wdata_next  = reg_wdata_o;
        wchan_next  = reg_wr_chan_o;
        rchan_next  = reg_rd_chan_o;
        wr_next     = 1'b0;
        rd_next     = 1'b0;
        srst_next   = 1'b0;
        oe_next     = (state_reg == ST_DATA) && read_reg && !csb_s;
        alt_next    = (state_reg == ST_IDLE) && csb_s;
        if (reg_rd_o) begin
            tx_next = rd_mux;
        end
        if (csb_rise) begin
            if (mid_byte || (state_reg == ST_INSTR && cnt_reg == 4'h0)
                    || (state_reg == ST_DATA && stream_reg)) begin
                state_next = ST_IDLE;
                cnt_next   = 4'h0;
            end
        end else if (sclk_rise && state_reg != ST_DATA) begin
            state_next = ST_INSTR;
            instr_next = instr_shift;
            cnt_next   = cnt_reg + 4'h1;
            if (cnt_reg == `SCP_INSTR_LAST) begin
                state_next  = ST_DATA;
                cnt_next    = 4'h0;
                read_next   = instr_shift[`SCP_RW_BIT];
                left_next   = len_code;
                stream_next = (len_code == `SCP_LEN_STREAM);
                addr_next   = instr_shift[`SCP_ADDR_W-1:0];
                if (instr_shift[`SCP_RW_BIT]) begin
                    oe_next    = 1'b1;
                    rd_next    = 1'b1;
                    raddr_next = instr_shift[`SCP_ADDR_W-1:0];
                    rchan_next = first_chan;
                end
            end
        end else if (sclk_rise) begin
            rx_next  = rx_shift;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == `SCP_BYTE_LAST) begin
                cnt_next  = 4'h0;
                addr_next = addr_step;
                if (!read_reg) begin
                    if (addr_reg == `SCP_ADDR_CFG) begin
                        lsb_next = rx_shift[`SCP_CFG_LSB_HI] | rx_shift[`SCP_CFG_LSB_LO];
                        if (rx_shift[`SCP_CFG_SRST_HI] | rx_shift[`SCP_CFG_SRST_LO]) begin
                            srst_next = 1'b1;
                            lsb_next  = 1'b0;
                            chan_next = `SCP_CHAN_DEF;
                        end
                    end else if (addr_reg == `SCP_ADDR_CHAN) begin
                        chan_next = rx_shift[`SCP_CHAN_N-1:0];
                    end else begin
                        wr_next    = 1'b1;
                        raddr_next = addr_reg;
                        wdata_next = rx_shift;
                        wchan_next = chan_reg;
                    end
                end
                if (!stream_reg && left_reg == 2'h0) begin
                    state_next = ST_INSTR;
                end else begin
                    if (!stream_reg) begin
                        left_next = left_reg - 2'h1;
                    end
                    if (read_reg) begin
                        rd_next    = 1'b1;
                        raddr_next = addr_step;
                        rchan_next = first_chan;
                    end
                end
            end
        end else if (sclk_fall && state_reg == ST_DATA && read_reg) begin
            dout_next = lsb_reg ? tx_reg[0] : tx_reg[7];
            tx_next   = lsb_reg ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
        end else if (state_reg == ST_IDLE && !csb_s) begin
            state_next = ST_INSTR;
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            sclk_d_reg    <= 1'b0;
            csb_d_reg     <= 1'b1;
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            instr_reg     <= 16'h0000;
            rx_reg        <= 8'h00;
            tx_reg        <= 8'h00;
            addr_reg      <= {`SCP_ADDR_W{1'b0}};
            read_reg      <= 1'b0;
            stream_reg    <= 1'b0;
            left_reg      <= 2'h0;
            lsb_reg       <= 1'b0;
            chan_reg      <= `SCP_CHAN_DEF;
            sdio_o        <= 1'b0;
            sdio_oe_o     <= 1'b0;
            alt_func_en_o <= 1'b0;
            reg_addr_o    <= {`SCP_ADDR_W{1'b0}};
            reg_wdata_o   <= 8'h00;
            reg_wr_o      <= 1'b0;
            reg_wr_chan_o <= {`SCP_CHAN_N{1'b0}};
            reg_rd_o      <= 1'b0;
            reg_rd_chan_o <= 2'h0;
            soft_reset_o  <= 1'b0;
        end else begin
            sclk_d_reg    <= sclk_s;
            csb_d_reg     <= csb_s;
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            instr_reg     <= instr_next;
            rx_reg        <= rx_next;
            tx_reg        <= tx_next;
            addr_reg      <= addr_next;
            read_reg      <= read_next;
            stream_reg    <= stream_next;
            left_reg      <= left_next;
            lsb_reg       <= lsb_next;
            chan_reg      <= chan_next;
            sdio_o        <= dout_next;
            sdio_oe_o     <= oe_next;
            alt_func_en_o <= alt_next;
            reg_addr_o    <= raddr_next;
            reg_wdata_o   <= wdata_next;
            reg_wr_o      <= wr_next;
            reg_wr_chan_o <= wchan_next;
            reg_rd_o      <= rd_next;
            reg_rd_chan_o <= rchan_next;
            soft_reset_o  <= srst_next;
        end
    end

endmodule // scp_port

//--- tb/scp_port_monitor.sv
// Concurrent checks on the serial configuration port pins and strobes.
// Assumes binding to scp_port; serial pins run far slower than clk_i.
`timescale 1ns/1ps
`include "scp_defines.vh"
module scp_port_monitor (
    input wire                   clk_i,            // System clock
    input wire                   rst_i,            // Synchronous reset
    input wire                   sclk_i,           // Serial clock pin
    input wire                   frame_select_n_i, // Frame select pin
    input wire                   sdio_o,           // Data pin value
    input wire                   sdio_oe_o,        // Data pin enable
    input wire                   alt_func_en_o,    // Secondary functions
    input wire                   reg_wr_o,         // Write strobe
    input wire                   reg_rd_o,         // Read strobe
    input wire [`SCP_CHAN_N-1:0] reg_wr_chan_o,    // Write channels
    input wire [1:0]             reg_rd_chan_o,    // Read channel
    input wire                   soft_reset_o,     // Soft reset pulse
    input wire                   lsb_first_o,      // Bit order
    input wire [`SCP_CHAN_N-1:0] chan_sel_o        // Channel selection
);
    reg       sclk_reg;
    reg [3:0] rise_reg;
    reg [3:0] fall_reg;
    // Cycles since the last serial clock edge of each kind
    always @(posedge clk_i) begin
        sclk_reg <= sclk_i;
        if (rst_i) begin
            rise_reg <= 4'hf;
            fall_reg <= 4'hf;
        end else begin
            rise_reg <= (sclk_i && !sclk_reg) ? 4'h0 : (rise_reg == 4'hf ? 4'hf : rise_reg + 4'h1);
            fall_reg <= (!sclk_i && sclk_reg) ? 4'h0 : (fall_reg == 4'hf ? 4'hf : fall_reg + 4'h1);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_sel_idle;
        frame_select_n_i [*6];
    endsequence
    sequence s_soft_done;
        ##1 !soft_reset_o ##1 (!lsb_first_o && chan_sel_o == `SCP_CHAN_DEF);
    endsequence
    chk_idle_quiet: assert property (s_sel_idle |-> !sdio_oe_o && !reg_wr_o && !reg_rd_o)
        else $error("port active while select high");
    chk_oe_turn: assert property ($rose(sdio_oe_o) |-> rise_reg inside {[1:5]} && !alt_func_en_o)
        else $error("data pin turned late");
    chk_bit_launch: assert property (sdio_oe_o && $past(sdio_oe_o) && $changed(sdio_o) |-> fall_reg inside {[1:5]})
        else $error("read bit not launched on falling edge");
    chk_wr_pulse: assert property (reg_wr_o |=> !reg_wr_o [*8])
        else $error("write strobe too long");
    chk_rd_pulse: assert property (reg_rd_o |-> !reg_wr_o ##1 !reg_rd_o [*8])
        else $error("read strobe too long");
    chk_rd_drive: assert property (reg_rd_o |-> sdio_oe_o)
        else $error("read without turnaround");
    chk_wr_chan: assert property (reg_wr_o |-> reg_wr_chan_o == chan_sel_o)
        else $error("write channel mask wrong");
    chk_rd_chan: assert property (reg_rd_o |-> chan_sel_o[reg_rd_chan_o]
        && ((chan_sel_o & ((4'h1 << reg_rd_chan_o) - 4'h1)) == 4'h0))
        else $error("read channel not lowest selected");
    chk_soft_clear: assert property (soft_reset_o |-> s_soft_done)
        else $error("soft reset did not restore defaults");
endmodule // scp_port_monitor
bind scp_port scp_port_monitor u_scp_mon (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
    .frame_select_n_i(frame_select_n_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .alt_func_en_o(alt_func_en_o),
    .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_wr_chan_o(reg_wr_chan_o), .reg_rd_chan_o(reg_rd_chan_o),
    .soft_reset_o(soft_reset_o), .lsb_first_o(lsb_first_o), .chan_sel_o(chan_sel_o));

//--- tb/scp_host_model.sv
// Serial controller model: drives serial clock, select and data pins.
// Assumes the bench resolves the shared data pin; calls start at negedge.
`timescale 1ns/1ps
module scp_host_model (
    input  wire clk_i,   // Bench clock
    input  wire pin_i,   // Resolved data pin
    output reg  sclk_o,  // Serial clock, still between frames
    output reg  sel_n_o, // Frame select, active low
    output reg  dat_o,   // Data drive value
    output reg  drv_o    // Data drive enable
);
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        dat_o = 1'b0;
        drv_o = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // One 80 ns bit: launch while low, sample late in the high phase
    task automatic xbit(input logic b, input logic drv, output logic r);
        sclk_o = 1'b0;
        dat_o = b;
        drv_o = drv;
        wait_n(4);
        sclk_o = 1'b1;
        wait_n(3);
        r = pin_i;
        wait_n(1);
    endtask
    task automatic xword(input logic [15:0] v, input int n, input logic lsb, input logic drv, output logic [15:0] r);
        int   idx;
        logic b;
        r = 16'h0000;
        for (int i = 0; i < n; i++) begin
            idx = lsb ? i : n - 1 - i;
            xbit(v[idx], drv, b);
            r[idx] = b;
        end
    endtask
    task automatic sel(input logic v);
        sclk_o = 1'b0;
        drv_o = 1'b0;
        wait_n(4);
        sel_n_o = v;
        wait_n(4);
    endtask
endmodule // scp_host_model

//--- tb/test_scp_port.sv
// Self-checking bench: scp_port against a behavioural port model.
// Assumes scp_host_model and the bound checker are compiled before it.
`timescale 1ns/1ps
`include "scp_defines.vh"
module test_scp_port;
    reg          clk_i = 1'b0;
    reg          rst_i = 1'b1;
    reg          last_pin = 1'b0;
    wire         sclk;
    wire         sel_n;
    wire         hdat;
    wire         hdrv;
    wire         sdio_o;
    wire         sdio_oe_o;
    wire         alt_o;
    wire         wr;
    wire         rd;
    wire         srst;
    wire         lsb;
    wire [12:0]  addr;
    wire [7:0]   wdata;
    wire [3:0]   wchan;
    wire [3:0]   csel;
    wire [1:0]   rchan;
    reg  [7:0]   ufile [0:8191];
    logic [7:0]  mdl [0:8191];
    logic [31:0] expq [$];
    logic [7:0]  wq [$];
    logic        m_lsb = 1'b0;
    logic [3:0]  m_chan = 4'hf;
    int          miscompares = 0, check_count = 0, soft_cnt = 0;
    // Released pin shows a changing pattern, never a held value
    wire         pin = sdio_oe_o ? sdio_o : (hdrv ? hdat : ~last_pin);
    wire [7:0]   rdata = ufile[addr];
    scp_port dut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .frame_select_n_i(sel_n), .sdio_i(pin),
        .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .alt_func_en_o(alt_o), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_wr_chan_o(wchan), .reg_rd_o(rd), .reg_rd_chan_o(rchan), .reg_rdata_i(rdata),
        .soft_reset_o(srst), .lsb_first_o(lsb), .chan_sel_o(csel));
    scp_host_model u_host (.clk_i(clk_i), .pin_i(pin), .sclk_o(sclk), .sel_n_o(sel_n), .dat_o(hdat), .drv_o(hdrv));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // ****************************************
    // User register file
    // ****************************************
    always @(posedge clk_i) begin
        last_pin <= pin;
        if (srst === 1'b1) begin
            soft_cnt <= soft_cnt + 1;
            for (int i = 0; i < 8192; i++) ufile[i] <= 8'h00;
        end
        if (wr === 1'b1) begin
            ufile[addr] <= wdata;
            chk("write", expq.size() ? expq.pop_front() : 32'hffffffff, {7'h00, addr, wdata, wchan});
        end
    end
    // ****************************************
    // Port model
    // ****************************************
    task automatic mwrite(input logic [12:0] a, input logic [7:0] d);
        if (a == `SCP_ADDR_CFG) begin
            m_lsb = (d[`SCP_CFG_SRST_HI] | d[`SCP_CFG_SRST_LO]) ? 1'b0 : (d[`SCP_CFG_LSB_HI] | d[`SCP_CFG_LSB_LO]);
            if (d[`SCP_CFG_SRST_HI] | d[`SCP_CFG_SRST_LO]) begin
                m_chan = `SCP_CHAN_DEF;
                for (int i = 0; i < 8192; i++) mdl[i] = 8'h00;
            end
        end else if (a == `SCP_ADDR_CHAN) m_chan = d[3:0];
        else begin
            mdl[a] = d;
            expq.push_back({7'h00, a, d, m_chan});
        end
    endtask
    function automatic logic [7:0] mread(input logic [12:0] a);
        if (a == `SCP_ADDR_CFG) return `SCP_CFG_FIXED | (m_lsb ? 8'h42 : 8'h00);
        if (a == `SCP_ADDR_CHAN) return {4'h0, m_chan};
        return mdl[a];
    endfunction
    // Mode bit 0: select already low, bit 1: keep low, bit 2: stall between bytes
    task automatic frame(input logic r, input logic [1:0] len, input logic [12:0] a, input int n, input int mode);
        logic [15:0] got;
        logic [7:0]  d;
        logic        o;
        if (!mode[0]) u_host.sel(1'b0);
        u_host.xword({r, len, a}, 16, m_lsb, 1'b1, got);
        for (int k = 0; k < n; k++) begin
            d = wq.size() ? wq.pop_front() : 8'($urandom);
            o = m_lsb;
            if (!r) mwrite(a, d);
            u_host.xword({8'h00, d}, 8, o, !r, got);
            if (r) chk("read", mread(a), got);
            a = o ? a + 13'h0001 : a - 13'h0001;
            if (mode[2] && k < n - 1) u_host.sel(1'b1);
            if (mode[2] && k < n - 1) u_host.sel(1'b0);
        end
        if (!mode[1]) u_host.sel(1'b1);
    endtask
    initial begin
        #500000;
        miscompares++;
        test_done();
    end
    initial begin
        logic       x;
        logic [1:0] l;
        void'($urandom(32'hbb959add));
        for (int i = 0; i < 8192; i++) ufile[i] = 8'h00;
        for (int i = 0; i < 8192; i++) mdl[i] = 8'h00;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        u_host.wait_n(4);
        chk("reset", 32'h1f, {lsb, csel, alt_o});
        for (int i = 0; i < 16; i++) u_host.xbit(1'b1, 1'b1, x);
        chk("idle", 32'h1, alt_o);
        $display("test reset and idle done");
        for (int c = 0; c < 3; c++) frame(1'b0, c[1:0], 13'h0100 + 13'(c * 16), c + 1, 0);
        frame(1'b1, 2'h3, 13'h0120, 3, 0);
        frame(1'b1, 2'h3, `SCP_ADDR_CHAN, 6, 0);
        frame(1'b0, 2'h2, 13'h0200, 3, 4);
        frame(1'b1, 2'h3, 13'h0200, 3, 0);
        $display("test lengths and stall done");
        frame(1'b0, 2'h0, 13'h0300, 1, 2);
        frame(1'b1, 2'h0, 13'h0300, 1, 1);
        u_host.sel(1'b0);
        for (int i = 0; i < 5; i++) u_host.xbit(1'b1, 1'b1, x);
        u_host.sel(1'b1);
        frame(1'b1, 2'h1, 13'h0300, 2, 0);
        $display("test streaming and abort done");
        wq.push_back(8'h06);
        frame(1'b0, 2'h0, `SCP_ADDR_CHAN, 1, 0);
        frame(1'b0, 2'h1, 13'h0400, 2, 0);
        frame(1'b1, 2'h1, 13'h0400, 2, 0);
        wq.push_back(8'h5a);
        frame(1'b0, 2'h0, `SCP_ADDR_CFG, 1, 0);
        chk("order", 32'h1, lsb);
        frame(1'b0, 2'h2, 13'h0500, 3, 0);
        frame(1'b1, 2'h3, 13'h0500, 3, 0);
        wq.push_back(8'h3c);
        frame(1'b0, 2'h0, `SCP_ADDR_CFG, 1, 0);
        u_host.wait_n(4);
        chk("soft", 32'h2f, {soft_cnt[3:0], lsb, csel});
        frame(1'b1, 2'h1, 13'h0501, 2, 0);
        $display("test channels order soft reset done");
        for (int i = 0; i < 6; i++) begin
            l = 2'($urandom);
            frame(1'(i), l, 13'h0100 + 13'($urandom % 256), (l == 2'h3) ? 4 : l + 1, 0);
        end
        chk("queue", 32'h0, expq.size());
        $display("test random frames done");
        test_done();
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
endmodule // test_scp_port
